/* verilog/bst_pkg.sv */
`default_nettype none
package bst_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int BST_IR_W = 5;          // Instruction register width
    localparam int BST_ID_W = 32;         // Identification word width
    localparam int BST_CHAIN_LEN = 54;    // Boundary cells 0..53

    // ------------------------------------------------------------
    // Instruction opcodes
    // ------------------------------------------------------------
    localparam logic [4:0] BST_OP_EXTEST = 5'h00;
    localparam logic [4:0] BST_OP_SAMPLE = 5'h01;
    localparam logic [4:0] BST_OP_CLAMP = 5'h04;
    localparam logic [4:0] BST_OP_HIGHZ = 5'h05;
    localparam logic [4:0] BST_OP_IDCODE = 5'h0C;
    localparam logic [4:0] BST_OP_BYPASS = 5'h1F;
    localparam logic [4:0] BST_IR_CAPTURE = 5'h01;  // Fixed 01 in the low bits
    localparam logic [4:0] BST_IR_RESET = BST_OP_IDCODE;

    // ------------------------------------------------------------
    // Identification word fields
    // ------------------------------------------------------------
    localparam int BST_ID_VER_LSB = 28;   // Version 31..28
    localparam int BST_ID_PART_LSB = 12;  // Part number 27..12
    localparam int BST_ID_MFR_LSB = 1;    // Maker code 11..1
    localparam logic BST_ID_FIXED = 1'b1; // Bit 0

    // ------------------------------------------------------------
    // Controller states, Gray steps along the usual walk
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        BST_TLR = 4'h0, BST_RTI = 4'h1, BST_SEL_DR = 4'h3, BST_CAP_DR = 4'h2,
        BST_SH_DR = 4'h6, BST_EX1_DR = 4'h7, BST_PAU_DR = 4'h5, BST_EX2_DR = 4'h4,
        BST_UPD_DR = 4'hC, BST_SEL_IR = 4'hD, BST_CAP_IR = 4'hF, BST_SH_IR = 4'hE,
        BST_EX1_IR = 4'hA, BST_PAU_IR = 4'hB, BST_EX2_IR = 4'h9, BST_UPD_IR = 4'h8
    } bst_state_t;

    // Boundary cell kinds
    typedef enum logic [2:0] {
        BST_K_OUT2 = 3'h0, BST_K_IN = 3'h1, BST_K_BIDIR = 3'h2,
        BST_K_CTRL = 3'h3, BST_K_INTERNAL = 3'h4
    } bst_kind_t;

    // Kind of each chain position
    function automatic bst_kind_t bst_kind_of(input int i);
        if (i <= 2 || i == 51) begin
            return BST_K_OUT2;
        end else if (i <= 5) begin
            return BST_K_IN;
        end else if (i == 12 || i == 45 || i == 53 || (i >= 20 && i <= 34 && i % 2 == 0)) begin
            return BST_K_CTRL;
        end else if (i == 38 || i == 40 || (i >= 42 && i <= 50 && i != 45 && i != 47)) begin
            return BST_K_INTERNAL;
        end else begin
            return BST_K_BIDIR;
        end
    endfunction : bst_kind_of

    // Control cell that enables a bidirectional cell
    function automatic int bst_ctrl_of(input int i);
        if (i <= 18) begin
            return 12;
        end else if (i <= 33) begin
            return i + 1;
        end else if (i == 52) begin
            return 53;
        end else begin
            return 45;
        end
    endfunction : bst_ctrl_of

    // Opcodes that route the boundary chain
    function automatic logic bst_sel_chain(input logic [4:0] op);
        return op == BST_OP_EXTEST || op == BST_OP_SAMPLE;
    endfunction : bst_sel_chain

    // Opcodes that put the chain update stage on the pins
    function automatic logic bst_drive_test(input logic [4:0] op);
        return op == BST_OP_EXTEST || op == BST_OP_CLAMP;
    endfunction : bst_drive_test

endpackage : bst_pkg
`default_nettype wire

/* verilog/bst_chain.sv */
`timescale 1ns/10ps
`default_nettype none
module bst_chain
    import bst_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic capture_en,
    input wire logic shift_en,
    input wire logic update_en,
    input wire logic tdi,
    input wire logic [BST_CHAIN_LEN-1:0] cap_data,
    output logic shift_lsb,
    output logic [BST_CHAIN_LEN-1:0] upd_q
);

    // ------------------------------------------------------------
    // Shift and update stages
    // ------------------------------------------------------------
    logic [BST_CHAIN_LEN-1:0] sh_r; // Shift stage, cell 0 nearest data out
    logic [BST_CHAIN_LEN-1:0] upd_r; // Update stage that feeds the pins

    // Parallel load, then serial shift from data in toward cell 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_r <= '0;
        end else if (capture_en) begin
            sh_r <= cap_data;
        end else if (shift_en) begin
            sh_r <= {tdi, sh_r[BST_CHAIN_LEN-1:1]};
        end
    end

    // Update stage holds its value outside the update state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upd_r <= '0;
        end else if (update_en) begin
            upd_r <= sh_r;
        end
    end

    assign shift_lsb = sh_r[0];
    assign upd_q = upd_r;

endmodule : bst_chain
`default_nettype wire

/* verilog/bst_tap.sv */
`timescale 1ns/10ps
`default_nettype none
module bst_tap
    import bst_pkg::*;
#(
    parameter logic [3:0] ID_VERSION = 4'h2,      // Arbitrary value
    parameter logic [15:0] ID_PART = 16'hA5C3,    // Arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h2B4     // Arbitrary value
)
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    input wire logic TRST_N,
    output logic TDO,
    output logic TDO_OE,
    input wire logic [BST_CHAIN_LEN-1:0] CORE_OUT,
    input wire logic [BST_CHAIN_LEN-1:0] CORE_OE,
    input wire logic [BST_CHAIN_LEN-1:0] PAD_IN,
    output logic [BST_CHAIN_LEN-1:0] PAD_OUT,
    output logic [BST_CHAIN_LEN-1:0] PAD_OE,
    output logic [BST_CHAIN_LEN-1:0] CORE_IN
);

    // ------------------------------------------------------------
    // Test reset: asynchronous entry, clean release
    // ------------------------------------------------------------
    wire logic rst_any_n; // Either power-on or test reset
    logic rs1_r; // First release flop
    logic rs2_r; // Release flop that drives the test logic
    wire logic tap_rst_n; // Reset of all test logic

    assign rst_any_n = RST_N & TRST_N;

    // Assert at once, release two clocks later
    always_ff @(posedge CLOCK or negedge rst_any_n) begin
        if (!rst_any_n) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end

    assign tap_rst_n = rs2_r;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic tck_s1_r; // Test clock, first stage
    logic tck_s2_r; // Test clock, second stage
    logic tck_d_r; // Delayed copy for edge finding
    logic tms_s1_r; // Mode select, first stage
    logic tms_s2_r; // Mode select, second stage
    logic tdi_s1_r; // Data in, first stage
    logic tdi_s2_r; // Data in, second stage
    logic [BST_CHAIN_LEN-1:0] pad_s1_r; // Pin levels, first stage
    logic [BST_CHAIN_LEN-1:0] pad_s2_r; // Pin levels, second stage

    // Clock, mode select and data in pass the same two stages so they stay aligned
    always_ff @(posedge CLOCK or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tck_s1_r <= 1'b0;
            tck_s2_r <= 1'b0;
            tck_d_r <= 1'b0;
            tms_s1_r <= 1'b1;
            tms_s2_r <= 1'b1;
            tdi_s1_r <= 1'b1;
            tdi_s2_r <= 1'b1;
        end else begin
            tck_s1_r <= TCK;
            tck_s2_r <= tck_s1_r;
            tck_d_r <= tck_s2_r;
            tms_s1_r <= TMS;
            tms_s2_r <= tms_s1_r;
            tdi_s1_r <= TDI;
            tdi_s2_r <= tdi_s1_r;
        end
    end

    // Pin inputs on the power-on reset only, they also feed the core
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pad_s1_r <= '0;
            pad_s2_r <= '0;
        end else begin
            pad_s1_r <= PAD_IN;
            pad_s2_r <= pad_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Test clock edges
    // ------------------------------------------------------------
    wire logic tck_rise; // One-cycle pulse per rising edge
    wire logic tck_fall; // One-cycle pulse per falling edge

    assign tck_rise = tck_s2_r & ~tck_d_r;
    assign tck_fall = ~tck_s2_r & tck_d_r;

    // ------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------
    bst_state_t state_r; // Current controller state
    bst_state_t state_nxt; // State after the next rising edge

    // Next state from mode select
    always_comb begin
        case (state_r)
            BST_TLR: state_nxt = tms_s2_r ? BST_TLR : BST_RTI;
            BST_RTI: state_nxt = tms_s2_r ? BST_SEL_DR : BST_RTI;
            BST_SEL_DR: state_nxt = tms_s2_r ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR: state_nxt = tms_s2_r ? BST_EX1_DR : BST_SH_DR;
            BST_SH_DR: state_nxt = tms_s2_r ? BST_EX1_DR : BST_SH_DR;
            BST_EX1_DR: state_nxt = tms_s2_r ? BST_UPD_DR : BST_PAU_DR;
            BST_PAU_DR: state_nxt = tms_s2_r ? BST_EX2_DR : BST_PAU_DR;
            BST_EX2_DR: state_nxt = tms_s2_r ? BST_UPD_DR : BST_SH_DR;
            BST_UPD_DR: state_nxt = tms_s2_r ? BST_SEL_DR : BST_RTI;
            BST_SEL_IR: state_nxt = tms_s2_r ? BST_TLR : BST_CAP_IR;
            BST_CAP_IR: state_nxt = tms_s2_r ? BST_EX1_IR : BST_SH_IR;
            BST_SH_IR: state_nxt = tms_s2_r ? BST_EX1_IR : BST_SH_IR;
            BST_EX1_IR: state_nxt = tms_s2_r ? BST_UPD_IR : BST_PAU_IR;
            BST_PAU_IR: state_nxt = tms_s2_r ? BST_EX2_IR : BST_PAU_IR;
            BST_EX2_IR: state_nxt = tms_s2_r ? BST_UPD_IR : BST_SH_IR;
            BST_UPD_IR: state_nxt = tms_s2_r ? BST_SEL_DR : BST_RTI;
            default: state_nxt = BST_TLR;
        endcase
    end

    // State advances on each rising test clock edge
    always_ff @(posedge CLOCK or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            state_r <= BST_TLR;
        end else if (tck_rise) begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    logic [BST_IR_W-1:0] ir_sh_r; // Instruction shift stage
    logic [BST_IR_W-1:0] ir_r; // Active instruction

    // Capture fixed pattern, shift toward data out
    always_ff @(posedge CLOCK or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_sh_r <= BST_IR_CAPTURE;
        end else if (tck_rise && state_r == BST_CAP_IR) begin
            ir_sh_r <= BST_IR_CAPTURE;
        end else if (tck_rise && state_r == BST_SH_IR) begin
            ir_sh_r <= {tdi_s2_r, ir_sh_r[BST_IR_W-1:1]};
        end
    end

    // New instruction takes effect on the falling edge in update
    always_ff @(posedge CLOCK or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_r <= BST_IR_RESET;
        end else if (state_r == BST_TLR) begin
            ir_r <= BST_IR_RESET;
        end else if (tck_fall && state_r == BST_UPD_IR) begin
            ir_r <= ir_sh_r;
        end
    end

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    wire logic sel_chain; // Boundary chain between data in and out
    wire logic sel_id; // Identification word selected
    wire logic sel_bypass; // Bypass stage selected, any other opcode
    wire logic drive_test; // Pins driven from the update stage
    wire logic float_all; // All pins floated

    assign sel_chain = bst_sel_chain(ir_r);
    assign sel_id = ir_r == BST_OP_IDCODE;
    assign sel_bypass = ~sel_chain & ~sel_id;
    assign drive_test = bst_drive_test(ir_r);
    assign float_all = ir_r == BST_OP_HIGHZ;

    // ------------------------------------------------------------
    // Bypass stage and identification word
    // ------------------------------------------------------------
    wire logic [BST_ID_W-1:0] id_word; // Constant identity
    logic bypass_r; // One-bit bypass stage
    logic [BST_ID_W-1:0] id_sh_r; // Identity shift stage
    wire logic dr_cap; // Rising edge in capture-DR
    wire logic dr_shift; // Rising edge in shift-DR

    assign id_word = {ID_VERSION, ID_PART, ID_MAKER, BST_ID_FIXED};
    assign dr_cap = tck_rise && state_r == BST_CAP_DR;
    assign dr_shift = tck_rise && state_r == BST_SH_DR;

    // Bypass captures zero, then passes data one bit late
    always_ff @(posedge CLOCK or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bypass_r <= 1'b0;
        end else if (dr_cap && sel_bypass) begin
            bypass_r <= 1'b0;
        end else if (dr_shift && sel_bypass) begin
            bypass_r <= tdi_s2_r;
        end
    end

    // Identity reloads at each capture while selected, then shifts toward data out
    always_ff @(posedge CLOCK or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            id_sh_r <= '0;
        end else if (dr_cap && sel_id) begin
            id_sh_r <= id_word;
        end else if (dr_shift && sel_id) begin
            id_sh_r <= {tdi_s2_r, id_sh_r[BST_ID_W-1:1]};
        end
    end

    // ------------------------------------------------------------
    // Boundary chain
    // ------------------------------------------------------------
    logic [BST_CHAIN_LEN-1:0] cap_data; // Parallel load per cell
    logic [BST_CHAIN_LEN-1:0] test_out; // Test level per cell
    logic [BST_CHAIN_LEN-1:0] test_oe; // Test enable per cell
    logic [BST_CHAIN_LEN-1:0] has_pin; // Cell drives a pin of its own
    wire logic [BST_CHAIN_LEN-1:0] upd_q; // Update stage of the chain
    wire logic chain_lsb; // Chain bit toward data out

    // Per-cell wiring by kind, in fixed chain order from cell 0
    for (genvar i = 0; i < BST_CHAIN_LEN; i++) begin : g_cell
        localparam bst_kind_t KIND = bst_kind_of(i);
        localparam int CTRL = bst_ctrl_of(i);
        if (KIND == BST_K_OUT2) begin : g_out2
            assign cap_data[i] = PAD_OUT[i];
            assign test_oe[i] = 1'b1;
            assign has_pin[i] = 1'b1;
        end else if (KIND == BST_K_IN) begin : g_in
            assign cap_data[i] = pad_s2_r[i];
            assign test_oe[i] = 1'b0;
            assign has_pin[i] = 1'b0; // Input only, never driven
        end else if (KIND == BST_K_BIDIR) begin : g_bidir
            assign cap_data[i] = pad_s2_r[i];
            assign test_oe[i] = upd_q[CTRL];
            assign has_pin[i] = 1'b1;
        end else begin : g_nopin
            assign cap_data[i] = 1'b0;
            assign test_oe[i] = 1'b0;
            assign has_pin[i] = 1'b0;
        end
        assign test_out[i] = upd_q[i];
    end

    bst_chain u_chain (
        .clk(CLOCK),
        .rst_n(tap_rst_n),
        .capture_en(dr_cap && sel_chain),
        .shift_en(dr_shift && sel_chain),
        .update_en(tck_fall && state_r == BST_UPD_DR && sel_chain),
        .tdi(tdi_s2_r),
        .cap_data(cap_data),
        .shift_lsb(chain_lsb),
        .upd_q(upd_q)
    );

    // ------------------------------------------------------------
    // Pin drive selection
    // ------------------------------------------------------------
    wire logic [BST_CHAIN_LEN-1:0] pad_out_nxt; // Level to drive
    wire logic [BST_CHAIN_LEN-1:0] pad_oe_nxt; // Enable to drive

    assign pad_out_nxt = has_pin & (drive_test ? test_out : CORE_OUT);
    assign pad_oe_nxt = float_all ? '0 :
        has_pin & (drive_test ? test_oe : CORE_OE);

    // Pins and core inputs leave from flops
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            PAD_OUT <= '0;
            PAD_OE <= '0;
            CORE_IN <= '0;
        end else begin
            PAD_OUT <= pad_out_nxt;
            PAD_OE <= pad_oe_nxt;
            CORE_IN <= pad_s2_r;
        end
    end

    // ------------------------------------------------------------
    // Test data out
    // ------------------------------------------------------------
    wire logic dr_lsb; // Bit of the selected data register
    wire logic tdo_nxt; // Level for the next falling edge

    assign dr_lsb = sel_chain ? chain_lsb : (sel_id ? id_sh_r[0] : bypass_r);
    assign tdo_nxt = state_r == BST_SH_IR ? ir_sh_r[0] : dr_lsb;

    // Data out changes on falling edges, enabled only while shifting
    always_ff @(posedge CLOCK or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            TDO <= 1'b0;
            TDO_OE <= 1'b0;
        end else if (tck_fall) begin
            TDO <= tdo_nxt;
            TDO_OE <= state_r == BST_SH_DR || state_r == BST_SH_IR;
        end
    end

endmodule : bst_tap
`default_nettype wire

/* verif/bst_tap_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module bst_tap_asserts
    import bst_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    input wire logic TRST_N,
    input wire logic TDO,
    input wire logic TDO_OE,
    input wire logic [BST_CHAIN_LEN-1:0] CORE_OUT,
    input wire logic [BST_CHAIN_LEN-1:0] CORE_OE,
    input wire logic [BST_CHAIN_LEN-1:0] PAD_IN,
    input wire logic [BST_CHAIN_LEN-1:0] PAD_OUT,
    input wire logic [BST_CHAIN_LEN-1:0] PAD_OE,
    input wire logic [BST_CHAIN_LEN-1:0] CORE_IN
);
    // ------------------------------------------------------------
    // Edge age counters and cell masks
    // ------------------------------------------------------------
    localparam logic [53:0] NOPIN_M = 54'h277D4555501000;  // Control and internal cells
    localparam logic [53:0] IN_M = 54'h38;  // Input-only cells
    logic tck_q;  // Last sampled test clock
    logic [3:0] fall_r;  // Cycles since a test clock fall
    logic [3:0] edge_r;  // Cycles since any test clock edge
    logic [2:0] up_r;  // Cycles since reset release
    wire logic [3:0] fall_nxt = (tck_q && !TCK) ? 4'h0 : fall_r + {3'h0, fall_r != 4'hF};
    wire logic [3:0] edge_nxt = (tck_q != TCK) ? 4'h0 : edge_r + {3'h0, edge_r != 4'hF};
    wire logic [2:0] up_nxt = up_r + {2'h0, up_r != 3'h7};
    // Track test clock edges seen by the system clock
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            tck_q <= 1'b0;
            fall_r <= 4'h0;
            edge_r <= 4'h0;
            up_r <= 3'h0;
        end else begin
            tck_q <= TCK;
            fall_r <= fall_nxt;
            edge_r <= edge_nxt;
            up_r <= up_nxt;
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N || !TRST_N);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    chk_trst_tdo_off: assert property (disable iff (!RST_N) !TRST_N |-> !TDO_OE && !TDO)
        else $error("data out active during test reset");
    chk_tdo_on_fall: assert property ($changed(TDO) |-> fall_r inside {[4'h1:4'h6]})
        else $error("data out moved away from a falling edge");
    chk_oe_rise_fall: assert property ($rose(TDO_OE) |-> fall_r inside {[4'h1:4'h6]})
        else $error("data out enable rose away from a falling edge");
    chk_oe_drop_fall: assert property ($fell(TDO_OE) |-> fall_r inside {[4'h1:4'h6]})
        else $error("data out enable fell away from a falling edge");
    chk_nopin_out: assert property ((PAD_OUT & NOPIN_M) == '0)
        else $error("pin value on a pinless cell");
    chk_nopin_oe: assert property ((PAD_OE & (NOPIN_M | IN_M)) == '0)
        else $error("enable on a pinless or input cell");
    chk_pad_by_edge: assert property ($changed(PAD_OE) || $changed(PAD_OUT) |-> edge_r <= 4'h6)
        else $error("pins moved without a test clock edge");
    chk_core_in_lag: assert property (up_r == 3'h7 |-> (CORE_IN & IN_M) == ($past(PAD_IN, 3) & IN_M))
        else $error("core input does not follow the pad");
    cover property ($rose(TDO_OE));
    cover property (PAD_OE == '0);
    cover property ($changed(PAD_OE) && edge_r != 4'h0);
endmodule : bst_tap_asserts
bind bst_tap bst_tap_asserts u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .TCK(TCK), .TMS(TMS),
    .TDI(TDI), .TRST_N(TRST_N), .TDO(TDO), .TDO_OE(TDO_OE), .CORE_OUT(CORE_OUT),
    .CORE_OE(CORE_OE), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .CORE_IN(CORE_IN));
`default_nettype wire

/* verif/bst_tester.sv */
`timescale 1ns/10ps
`default_nettype none
module bst_tester (
    input wire logic clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // ------------------------------------------------------------
    // Test port driver, five pins
    // ------------------------------------------------------------
    wire logic tdo_line = tdo_oe ? tdo : 1'b1;  // Pulled high when released
    initial begin
        tck = 1'b0;  // Stands low between frames
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end
    // One test clock: low phase, sample, high phase
    task automatic bit_op(input logic tms_v, input logic tdi_v, output logic tdo_v);
        tms = tms_v;  // Stable across the rising edge
        tdi = tdi_v;
        repeat (10) @(posedge clk);
        #1;
        tdo_v = tdo_line;
        tck = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        tck = 1'b0;
    endtask : bit_op
    // Scan n bits, LSB first, from idle back to idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic t;
        dout = '0;
        bit_op(1'b1, 1'b0, t);
        if (ir) begin
            bit_op(1'b1, 1'b0, t);
        end
        bit_op(1'b0, 1'b0, t);
        bit_op(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            bit_op(logic'(i == n - 1), din[i], t);
            dout[i] = t;
        end
        bit_op(1'b1, 1'b0, t);
        bit_op(1'b0, 1'b0, t);
    endtask : scan
    // Short test reset pulse
    task automatic reset_pulse();
        trst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        trst_n = 1'b1;
    endtask : reset_pulse
endmodule : bst_tester
`default_nettype wire

/* verif/bst_tap_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module bst_tap_tb
    import bst_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus values and masks
    // ------------------------------------------------------------
    localparam logic [53:0] NOPIN_M = 54'h277D4555501000;  // Control and internal
    localparam logic [53:0] IN_M = 54'h38;  // Input cells
    localparam logic [53:0] OUT2_M = 54'h8000000000007;  // Output-only cells
    localparam logic [53:0] CTL_M = 54'h20200555501000;  // Control cells
    localparam logic [53:0] DRV_M = ~(NOPIN_M | IN_M);  // Cells with a driver
    localparam logic [53:0] GRP_M = 54'hFEFC0;  // Bidirectionals of cells 12 and 20
    localparam logic [53:0] A_V = 54'h1B4F0E96C3A55A;
    localparam logic [53:0] B_V = 54'h2C3AF05A961EB7;
    localparam logic [53:0] P1_V = 54'h35A91C6E0F4BD2 | CTL_M;  // All controls on
    localparam logic [63:0] ID_V = {32'h0, 4'h3, 16'h1357, 11'h0A6, 1'b1};
    logic clock, rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe, t;
    logic [53:0] core_out, core_oe, pad_out, pad_oe, core_in, ext_r;
    logic [63:0] d;
    logic [4:0] ops [6] = '{5'h1F, 5'h02, 5'h09, 5'h0A, 5'h13, BST_OP_HIGHZ};
    int num_errors = 0;
    int check_count = 0;
    wire logic [53:0] pad_in = (pad_oe & pad_out) | (~pad_oe & ext_r);  // Wire level
    bst_tap #(.ID_VERSION(4'h3), .ID_PART(16'h1357), .ID_MAKER(11'h0A6))  // Arbitrary
    uut (.CLOCK(clock), .RST_N(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n),
        .TDO(tdo), .TDO_OE(tdo_oe), .CORE_OUT(core_out), .CORE_OE(core_oe), .PAD_IN(pad_in),
        .PAD_OUT(pad_out), .PAD_OE(pad_oe), .CORE_IN(core_in));
    bst_tester u_tst (.clk(clock), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo(tdo), .tdo_oe(tdo_oe));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic load_ir(input logic [4:0] op);
        u_tst.scan(1'b1, 5, 64'(op), d);
    endtask : load_ir
    task automatic id_check();
        u_tst.scan(1'b0, 32, '0, d);
        chk(d, ID_V, "identity word");
    endtask : id_check
    task automatic byp_check();
        u_tst.scan(1'b0, 8, 64'hB5, d);
        chk(d, 64'h6A, "bypass path");
    endtask : byp_check
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    // Hang guard
    initial begin
        repeat (60000) @(posedge clock);
        num_errors++;
        summarize();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        core_out = A_V;
        core_oe = '1;
        ext_r = B_V;
        repeat (8) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (6) @(posedge clock);
        #1;
        u_tst.bit_op(1'b0, 1'b0, t);
        id_check();
        u_tst.scan(1'b1, 5, 64'(BST_OP_BYPASS), d);
        chk(d, 64'h1, "instruction capture");
        foreach (ops[k]) begin
            load_ir(ops[k]);
            byp_check();
        end
        chk(pad_oe, 64'h0, "all pins floated");
        load_ir(BST_OP_SAMPLE);
        u_tst.scan(1'b0, 54, 64'(P1_V), d);
        chk(d, (A_V & DRV_M) | (B_V & IN_M), "sample capture");
        chk(pad_out, A_V & DRV_M, "normal pin values");
        chk(pad_oe, DRV_M, "normal pin enables");
        chk(core_in & IN_M, B_V & IN_M, "core sees pads");
        load_ir(BST_OP_EXTEST);
        chk(pad_out, P1_V & DRV_M, "test pin values");
        chk(pad_oe, DRV_M, "controls enable bidirectionals");
        u_tst.scan(1'b0, 54, 64'h101000, d);
        chk(d, (P1_V & DRV_M) | (B_V & IN_M), "test capture");
        chk(pad_oe, OUT2_M | GRP_M, "group and pin controls");
        u_tst.scan(1'b0, 54, 64'h0, d);
        chk(d, B_V & (IN_M | (DRV_M & ~OUT2_M & ~GRP_M)), "capture from wire");
        load_ir(BST_OP_CLAMP);
        chk(pad_oe, OUT2_M, "clamped enables");
        chk(pad_out, 64'h0, "clamped values");
        byp_check();
        repeat (5) u_tst.bit_op(1'b1, 1'b0, t);
        u_tst.bit_op(1'b0, 1'b0, t);
        chk(pad_oe, DRV_M, "reset by mode select");
        id_check();
        load_ir(BST_OP_BYPASS);
        u_tst.bit_op(1'b1, 1'b0, t);
        u_tst.bit_op(1'b0, 1'b0, t);
        u_tst.bit_op(1'b0, 1'b0, t);
        u_tst.bit_op(1'b0, 1'b1, t);
        u_tst.reset_pulse();
        chk(tdo_oe, 64'h0, "data out released");
        u_tst.bit_op(1'b0, 1'b0, t);
        id_check();
        summarize();
    end
endmodule : bst_tap_tb
`default_nettype wire
